/* File: testbench/fan_tach_temp_dac_readout_tb_top.sv */
// Self-checking bench for the fan, drive and temperature back-end
`timescale 1ns/1ps
module fan_tach_temp_dac_readout_tb_top;
  import ftd_pkg::*;
  localparam int HALF_NS = 88900;
  localparam int REV_CYC = 4 * HALF_NS / 25;
  localparam int EXP_A = REV_CYC / (REF_DIV * 2);
  localparam int EXP_B = REV_CYC / REF_DIV;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [11:0] temp_sample = 12'hFF8;
  logic nand_tree_req = 1'b0;
  logic [15:0] reg_rdata;
  logic [7:0] fan_drive_output;
  logic tach_a, tach_b, volt_convert_strobe, hi_al, lo_al, cr_al, nand_tree_active;
  logic [15:0] got;
  logic [7:0] d;
  int miscompares = 0;
  int cmp_count = 0;
  logic [3:0] ra [0:6] = '{OFF_HIGH, OFF_HIREL, OFF_LOW, OFF_CRIT, OFF_HYST, OFF_DIV, OFF_CTL};
  logic [7:0] rv [0:6] = '{HIGH_RESET, HIREL_RESET, LOW_RESET, CRIT_RESET, {5'h00, HYST_RESET}, 8'h05, CTL_RESET};

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  ftd_monitor #(.LOOP_CYC(200)) u_ftd_monitor (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tach_input_a(tach_a), .tach_input_b(tach_b), .temp_sample(temp_sample), .nand_tree_req(nand_tree_req),
    .fan_drive_output(fan_drive_output), .volt_convert_strobe(volt_convert_strobe), .temp_high_alarm(hi_al),
    .temp_low_alarm(lo_al), .temp_crit_alarm(cr_al), .nand_tree_active(nand_tree_active));
  ftd_fan_model #(.HALF_NS(HALF_NS)) u_ftd_fan_model (.tach_a(tach_a), .tach_b(tach_b));

  // Compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One write strobe, held across its sampling edge
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    #2;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #2;
    reg_wr = 1'b0;
  endtask
  // One read strobe; data is registered at the taking edge
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #2;
    reg_rd = 1'b0;
    got = reg_rdata;
  endtask
  // Wait for the voltage slot of the next loop pass
  task automatic wait_slot;
    int n = 0;
    while (volt_convert_strobe !== 1'b1 && n < 60000) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    chk({15'h0000, n < 60000}, 16'h0001);
    repeat (2) @(posedge sys_clk);
    #2;
  endtask
  task automatic conclude;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cut a hang short
  initial begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    conclude();
  end

  // Test sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i]);
      chk(got, {8'h00, rv[i]});
    end
    rd(OFF_DAC);
    chk(got, 16'h00FF);
    rd(OFF_CNT_A);
    chk(got, 16'h00FF);
    $display("test reset_values done");
    wait_slot();
    rd(OFF_TEMP);
    chk(got, 16'h01FF);
    chk({13'h0000, hi_al, lo_al, cr_al}, 16'h0002);
    wr(OFF_TEMP, 8'h00);
    rd(OFF_TEMP);
    chk(got, 16'h01FF);
    $display("test normal_reading done");
    for (int i = 0; i < 5; i++) begin
      d = 8'hA5 ^ 8'(i);
      wr(ra[i], d);
      rd(ra[i]);
      chk(got, (i == 4) ? {13'h0000, d[2:0]} : {8'h00, d});
    end
    rd(4'hC);
    chk(got, 16'h0000);
    // Full drive first, then the reduced code
    wr(OFF_DAC, 8'hFF);
    repeat (40) @(posedge sys_clk);
    wr(OFF_DAC, 8'h40);
    chk({8'h00, fan_drive_output}, 16'h0040);
    wr(OFF_CTL, 8'h81);
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      chk(got, {8'h00, rv[i]});
    end
    rd(OFF_DAC);
    chk(got, 16'h0040);
    $display("test setpoints_drive done");
    wr(OFF_DIV, 8'h01);
    rd(OFF_DIV);
    chk(got, 16'h0001);
    wr(OFF_CTL, 8'h03);
    wr(OFF_HIGH, 8'h19);
    wr(OFF_CRIT, 8'h7D);
    temp_sample = 12'h7D1;
    wait_slot();
    rd(OFF_TEMP);
    chk(got, 16'h07D1);
    chk({13'h0000, hi_al, lo_al, cr_al}, 16'h0005);
    rd(OFF_CNT_A);
    chk({15'h0000, got >= EXP_A - 1 && got <= EXP_A + 1}, 16'h0001);
    chk({15'h0000, got < 16'h00DB}, 16'h0001);
    rd(OFF_CNT_B);
    chk({15'h0000, got >= EXP_B - 1 && got <= EXP_B + 1}, 16'h0001);
    // Status mirrors the alarm pins: crit and high set, low clear
    rd(OFF_STAT);
    chk(got, 16'h0005);
    $display("test fans_extended done");
    nand_tree_req = 1'b1;
    repeat (4) @(posedge sys_clk);
    #2;
    chk({15'h0000, nand_tree_active}, 16'h0001);
    wr(OFF_DAC, 8'h10);
    chk({8'h00, fan_drive_output}, 16'h0040);
    rd(OFF_DAC);
    chk(got, 16'h0000);
    $display("test test_mode done");
    conclude();
  end
endmodule

/* File: testbench/ftd_fan_model.sv */
// Two-pulse fan pair with chattering tach edges
`timescale 1ns/1ps
module ftd_fan_model #(
  parameter int HALF_NS = 88900,
  parameter int SKEW_NS = 30000,
  parameter int GL_NS = 50
) (
  // Tach pins
  output logic tach_a,
  output logic tach_b
);
  initial tach_a = 1'b0;
  initial tach_b = 1'b0;
  // slow edges
  // Each edge chatters with short spikes, far below the filter time
  always begin
    #(HALF_NS - 6 * GL_NS);
    repeat (6) begin
      tach_a = ~tach_a;
      #(GL_NS);
    end
    tach_a = ~tach_a;
  end
  // two pulses
  // Fan B is the same two-pulse fan, shifted in phase
  always @(tach_a) tach_b <= #(SKEW_NS) tach_a;
endmodule

/* File: testbench/ftd_monitor_props.sv */
// Port-level property checker for the fan, drive and temperature back-end
`timescale 1ns/1ps
module ftd_monitor_props
  import ftd_pkg::*;
#(
  parameter int unsigned LOOP_CYC = 200
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register access
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Pins and converter
  input wire logic tach_input_a,
  input wire logic tach_input_b,
  input wire logic [11:0] temp_sample,
  input wire logic nand_tree_req,
  // Outputs
  input wire logic [7:0] fan_drive_output,
  input wire logic volt_convert_strobe,
  input wire logic temp_high_alarm,
  input wire logic temp_low_alarm,
  input wire logic temp_crit_alarm,
  input wire logic nand_tree_active
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Accepted drive-code accesses
  wire drv_wr = reg_wr && reg_addr == OFF_DAC && !nand_tree_active;
  wire drv_rd = reg_rd && !reg_wr && reg_addr == OFF_DAC && !nand_tree_active;

  // Temperature step: alarms move, then the voltage slot follows
  sequence alarm_moved;
    $changed(temp_high_alarm) || $changed(temp_low_alarm) || $changed(temp_crit_alarm);
  endsequence
  sequence volt_slot;
    ##[1:2] volt_convert_strobe;
  endsequence

  drive_follow_a: assert property (drv_wr |=> fan_drive_output == $past(reg_wdata))
    else $error("drive code did not follow write");
  drive_hold_a: assert property (!drv_wr |=> $stable(fan_drive_output))
    else $error("drive code moved without write");
  drive_read_a: assert property (drv_rd |=> reg_rdata == {8'h00, $past(fan_drive_output)})
    else $error("drive code readback wrong");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (reg_rd && reg_addr > OFF_STAT |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  test_enter_a: assert property (nand_tree_req [*4] |-> nand_tree_active)
    else $error("test mode not entered");
  test_read_a: assert property (nand_tree_active && reg_rd |=> reg_rdata == 16'h0000)
    else $error("read answered in test mode");
  test_quiet_a: assert property (nand_tree_active [*3] |-> !volt_convert_strobe)
    else $error("loop ran in test mode");
  alarm_slot_a: assert property (alarm_moved |-> volt_slot)
    else $error("alarm changed outside temperature step");
  strobe_pulse_a: assert property (volt_convert_strobe |=> !volt_convert_strobe)
    else $error("voltage strobe longer than one cycle");
endmodule

bind ftd_monitor ftd_monitor_props #(.LOOP_CYC(LOOP_CYC)) u_ftd_monitor_props (.sys_clk, .rst_n,
  .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .tach_input_a, .tach_input_b, .temp_sample,
  .nand_tree_req, .fan_drive_output, .volt_convert_strobe, .temp_high_alarm, .temp_low_alarm,
  .temp_crit_alarm, .nand_tree_active);

/* File: verilog/ftd_meas_if.sv */
// Control link between the loop sequencer and one tach counter
`timescale 1ns/1ps
interface ftd_meas_if;
  logic start;
  logic [1:0] div_sel;
  logic ref_tick;
  logic done;
  logic [7:0] count;
  modport ctrl(output start, output div_sel, output ref_tick, input done, input count);
  modport meas(input start, input div_sel, input ref_tick, output done, output count);
endinterface

/* File: verilog/ftd_monitor.sv */
// Fan tach, fan drive code and temperature comparator back-end
`timescale 1ns/1ps
// Contract
// - Count 22.5 kHz reference ticks over two tach periods (one revolution) in an 8-bit counter.
// - Fan divisor is 1, 2, 4 or 8, and resets to 2.
// - Count equals 1.35e6 over RPM times divisor; 4400 RPM at 2 reads 153.
// - Each fan channel has its own divisor field.
// - Slow tach edges are filtered so each transition counts once.
// - Fan drive is an 8-bit code, zero to full scale.
// - Fan drive code is full scale after power-on.
// - Forcing the drive pin high enters test mode; normal responses stop.
// - Temperature is compared with high, low and critical setpoints plus hysteresis.
// - Default reading is 9-bit two's complement, half-degree steps.
// - Extended mode reading is 12-bit two's complement, sixteenth-degree steps.
// - Setpoints are 8-bit two's complement, one-degree steps.
// - Hysteresis offset is 3-bit unsigned degrees used by the comparator.
// - Reading is read-only; setpoints and hysteresis are read-write.
// - Drive output follows a write at once; soft init leaves it alone.
// - Loop measures temperature, voltages, fan A, fan B, about every 400 ms.
module ftd_monitor
  import ftd_pkg::*;
#(
  parameter int unsigned LOOP_CYC = LOOP_CYC_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register access
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Fan tach pins
  input wire logic tach_input_a,
  input wire logic tach_input_b,
  // Temperature converter result
  input wire logic [11:0] temp_sample,
  // Test mode detector on the drive pin
  input wire logic nand_tree_req,
  // Outputs
  output logic [7:0] fan_drive_output,
  output logic volt_convert_strobe,
  output logic temp_high_alarm,
  output logic temp_low_alarm,
  output logic temp_crit_alarm,
  output logic nand_tree_active
);
  // Register state
  logic [11:0] temp_raw;
  logic [7:0] high_temp_setpoint;
  logic [7:0] high_temp_release_setpoint;
  logic [7:0] low_temp_setpoint;
  logic [7:0] critical_temp_setpoint;
  logic [2:0] temp_hysteresis_offset;
  logic [3:0] fan_divisor_select;
  logic [7:0] ctl;
  logic [7:0] fan_count [2];
  logic [15:0] next_rdata;
  // Sequencer and timing
  ftd_loop_t state;
  logic [LOOP_W-1:0] loop_cnt;
  logic [REF_W-1:0] ref_cnt;
  logic ref_tick;
  logic test_s1;
  logic fan_start [2];
  // Per-channel links
  ftd_meas_if meas_if [2] ();

  // Access decode, blocked in test mode
  wire acc_ok = ~nand_tree_active;
  wire wr_en = reg_wr & acc_ok;
  wire wr_high = wr_en && reg_addr == OFF_HIGH;
  wire wr_hirel = wr_en && reg_addr == OFF_HIREL;
  wire wr_low = wr_en && reg_addr == OFF_LOW;
  wire wr_crit = wr_en && reg_addr == OFF_CRIT;
  wire wr_hyst = wr_en && reg_addr == OFF_HYST;
  wire wr_div = wr_en && reg_addr == OFF_DIV;
  wire wr_dac = wr_en && reg_addr == OFF_DAC;
  wire wr_ctl = wr_en && reg_addr == OFF_CTL;
  wire soft_init_command = wr_ctl & reg_wdata[CTL_INIT_BIT];
  wire ext_mode = ctl[CTL_EXT_BIT];
  wire loop_en = ctl[CTL_LOOP_BIT];
  wire loop_due = loop_cnt == LOOP_W'(LOOP_CYC - 1);
  wire ref_last = ref_cnt == REF_W'(REF_DIV - 1);

  // normal reading drops the sixteenth bits
  wire [11:0] temp_reading = ext_mode ? temp_raw : {3'h0, temp_raw[11:NORM_SHIFT]};

  // operands in sixteenth-degree units, 13-bit signed
  wire [11:0] t_cmp = ext_mode ? temp_sample : {temp_sample[11:NORM_SHIFT], 3'h0};
  wire signed [12:0] t13 = $signed({t_cmp[11], t_cmp});
  wire signed [12:0] hi13 = $signed({high_temp_setpoint[7], high_temp_setpoint, 4'h0});
  wire signed [12:0] rel13 = $signed({high_temp_release_setpoint[7], high_temp_release_setpoint, 4'h0});
  wire signed [12:0] lo13 = $signed({low_temp_setpoint[7], low_temp_setpoint, 4'h0});
  wire signed [12:0] cr13 = $signed({critical_temp_setpoint[7], critical_temp_setpoint, 4'h0});
  // unsigned hysteresis in the same units
  wire signed [12:0] hy13 = $signed({6'h00, temp_hysteresis_offset, 4'h0});
  wire signed [12:0] hi_clr_lvl = ext_mode ? hi13 - hy13 : rel13;
  wire high_set = t13 > hi13;
  wire high_clr = t13 <= hi_clr_lvl;
  wire low_set = t13 <= lo13;
  wire low_clr = t13 > lo13 + hy13;
  wire crit_set = t13 > cr13;
  wire crit_clr = t13 <= cr13 - hy13;
  wire temp_step = state == L_TEMP;

  // Channel links and counters
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_fan
      // each channel picks its own divisor field
      assign meas_if[ch].div_sel = fan_divisor_select[2*ch+1:2*ch];
      assign meas_if[ch].ref_tick = ref_tick;
      assign meas_if[ch].start = fan_start[ch];
      ftd_tach_counter u_tach (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .mi(meas_if[ch]),
        .tach_raw(ch == 0 ? tach_input_a : tach_input_b)
      );
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          fan_count[ch] <= COUNT_MAX;
        end else if (meas_if[ch].done) begin
          fan_count[ch] <= meas_if[ch].count;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt <= '0;
      ref_tick <= 1'b0;
    end else begin
      ref_tick <= ref_last;
      ref_cnt <= ref_last ? '0 : ref_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_s1 <= 1'b0;
      nand_tree_active <= 1'b0;
    end else begin
      test_s1 <= nand_tree_req;
      nand_tree_active <= test_s1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_cnt <= '0;
    end else if (!loop_en || nand_tree_active || loop_due) begin
      loop_cnt <= '0;
    end else begin
      loop_cnt <= loop_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= L_WAIT;
      volt_convert_strobe <= 1'b0;
      fan_start[0] <= 1'b0;
      fan_start[1] <= 1'b0;
    end else begin
      volt_convert_strobe <= 1'b0;
      fan_start[0] <= 1'b0;
      fan_start[1] <= 1'b0;
      case (state)
        L_WAIT: begin
          if (loop_due && loop_en && !nand_tree_active) begin
            state <= L_TEMP;
          end
        end
        L_TEMP: begin
          state <= L_VOLT;
        end
        L_VOLT: begin
          volt_convert_strobe <= 1'b1;
          state <= L_FAN_A;
        end
        L_FAN_A: begin
          fan_start[0] <= 1'b1;
          state <= L_WAIT_A;
        end
        L_WAIT_A: begin
          if (meas_if[0].done) begin
            state <= L_FAN_B;
          end
        end
        L_FAN_B: begin
          fan_start[1] <= 1'b1;
          state <= L_WAIT_B;
        end
        L_WAIT_B: begin
          if (meas_if[1].done) begin
            state <= L_WAIT;
          end
        end
        default: begin
          state <= L_WAIT;
        end
      endcase
    end
  end

  // capture the full 12-bit sample each loop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_raw <= '0;
    end else if (temp_step) begin
      temp_raw <= temp_sample;
    end
  end

  // high alarm, set wins over release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_high_alarm <= 1'b0;
    end else if (temp_step && high_set) begin
      temp_high_alarm <= 1'b1;
    end else if (temp_step && high_clr) begin
      temp_high_alarm <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_low_alarm <= 1'b0;
    end else if (temp_step && low_set) begin
      temp_low_alarm <= 1'b1;
    end else if (temp_step && low_clr) begin
      temp_low_alarm <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_crit_alarm <= 1'b0;
    end else if (temp_step && crit_set) begin
      temp_crit_alarm <= 1'b1;
    end else if (temp_step && crit_clr) begin
      temp_crit_alarm <= 1'b0;
    end
  end

  // writable high setpoints, restored by soft init
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_temp_setpoint <= HIGH_RESET;
      high_temp_release_setpoint <= HIREL_RESET;
    end else if (soft_init_command) begin
      high_temp_setpoint <= HIGH_RESET;
      high_temp_release_setpoint <= HIREL_RESET;
    end else begin
      if (wr_high) high_temp_setpoint <= reg_wdata;
      if (wr_hirel) high_temp_release_setpoint <= reg_wdata;
    end
  end

  // writable low, critical and hysteresis values
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_temp_setpoint <= LOW_RESET;
      critical_temp_setpoint <= CRIT_RESET;
      temp_hysteresis_offset <= HYST_RESET;
    end else if (soft_init_command) begin
      low_temp_setpoint <= LOW_RESET;
      critical_temp_setpoint <= CRIT_RESET;
      temp_hysteresis_offset <= HYST_RESET;
    end else begin
      if (wr_low) low_temp_setpoint <= reg_wdata;
      if (wr_crit) critical_temp_setpoint <= reg_wdata;
      if (wr_hyst) temp_hysteresis_offset <= reg_wdata[2:0];
    end
  end

  // divisor fields reset to divide by 2
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fan_divisor_select <= {DIV_RESET, DIV_RESET};
    end else if (soft_init_command) begin
      fan_divisor_select <= {DIV_RESET, DIV_RESET};
    end else if (wr_div) begin
      fan_divisor_select <= reg_wdata[3:0];
    end
  end

  // Control; the init bit never stays set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= CTL_RESET;
    end else if (soft_init_command) begin
      ctl <= CTL_RESET;
    end else if (wr_ctl) begin
      ctl <= {1'b0, reg_wdata[6:0]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fan_drive_output <= DAC_RESET;
    end else if (wr_dac) begin
      // 8-bit code straight to the pin
      fan_drive_output <= reg_wdata;
    end
  end

  // Read multiplexer
  always_comb begin
    next_rdata = '0;
    case (reg_addr)
      OFF_TEMP: next_rdata = {4'h0, temp_reading};
      OFF_HIGH: next_rdata = {8'h00, high_temp_setpoint};
      OFF_HIREL: next_rdata = {8'h00, high_temp_release_setpoint};
      OFF_LOW: next_rdata = {8'h00, low_temp_setpoint};
      OFF_CRIT: next_rdata = {8'h00, critical_temp_setpoint};
      OFF_HYST: next_rdata = {13'h0000, temp_hysteresis_offset};
      OFF_DIV: next_rdata = {12'h000, fan_divisor_select};
      OFF_DAC: next_rdata = {8'h00, fan_drive_output};
      OFF_CNT_A: next_rdata = {8'h00, fan_count[0]};
      OFF_CNT_B: next_rdata = {8'h00, fan_count[1]};
      OFF_CTL: next_rdata = {8'h00, ctl};
      OFF_STAT: next_rdata = {12'h000, nand_tree_active, temp_crit_alarm, temp_low_alarm, temp_high_alarm};
      default: next_rdata = '0;
    endcase
  end

  // read data, silent in test mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= acc_ok ? next_rdata : '0;
    end
  end
endmodule

/* File: verilog/ftd_pkg.sv */
// Shared constants and state types for the fan, drive code and temperature back-end
package ftd_pkg;
  // Clock and reference rates
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned REF_HZ = 22_500;
  localparam int unsigned REF_DIV = (CLK_HZ + REF_HZ / 2) / REF_HZ;
  localparam int unsigned REF_W = 11;
  // Tach edge filter: a new level must hold this long
  localparam int unsigned FILT_NS = 2000;
  localparam int unsigned FILT_CYC = (FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FILT_W = 7;
  // Monitoring loop period
  localparam int unsigned LOOP_MS = 400;
  localparam int unsigned LOOP_CYC_DEF = LOOP_MS * (CLK_HZ / 1000);
  localparam int unsigned LOOP_W = 24;
  // Tach pulses per counted period (two-pulse fan, one revolution)
  localparam int unsigned TACH_EDGES = 2;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  // Reset values
  localparam logic [1:0] DIV_RESET = 2'h1;
  localparam logic [7:0] DAC_RESET = 8'hFF;
  localparam logic [7:0] HIGH_RESET = 8'h3C;
  localparam logic [7:0] HIREL_RESET = 8'h37;
  localparam logic [7:0] LOW_RESET = 8'h0A;
  localparam logic [7:0] CRIT_RESET = 8'h50;
  localparam logic [2:0] HYST_RESET = 3'h2;
  localparam logic [7:0] CTL_RESET = 8'h01;
  // Register offsets
  localparam logic [3:0] OFF_TEMP = 4'h0;
  localparam logic [3:0] OFF_HIGH = 4'h1;
  localparam logic [3:0] OFF_HIREL = 4'h2;
  localparam logic [3:0] OFF_LOW = 4'h3;
  localparam logic [3:0] OFF_CRIT = 4'h4;
  localparam logic [3:0] OFF_HYST = 4'h5;
  localparam logic [3:0] OFF_DIV = 4'h6;
  localparam logic [3:0] OFF_DAC = 4'h7;
  localparam logic [3:0] OFF_CNT_A = 4'h8;
  localparam logic [3:0] OFF_CNT_B = 4'h9;
  localparam logic [3:0] OFF_CTL = 4'hA;
  localparam logic [3:0] OFF_STAT = 4'hB;
  // Field positions
  localparam int unsigned CTL_LOOP_BIT = 0;
  localparam int unsigned CTL_EXT_BIT = 1;
  localparam int unsigned CTL_INIT_BIT = 7;
  localparam int unsigned DIV_A_LSB = 0;
  localparam int unsigned DIV_B_LSB = 2;
  localparam int unsigned NORM_SHIFT = 3;
  // Loop sequencer states
  typedef enum logic [2:0] {
    L_WAIT = 3'h0,
    L_TEMP = 3'h1,
    L_VOLT = 3'h2,
    L_FAN_A = 3'h3,
    L_WAIT_A = 3'h4,
    L_FAN_B = 3'h5,
    L_WAIT_B = 3'h6
  } ftd_loop_t;
  // Tach counter states
  typedef enum logic [1:0] {
    T_IDLE = 2'h0,
    T_ARM = 2'h1,
    T_GATE = 2'h2
  } ftd_tach_t;
endpackage

/* File: verilog/ftd_tach_counter.sv */
// One fan tach period counter with input conditioning and saturation
`timescale 1ns/1ps
module ftd_tach_counter
  import ftd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Sequencer link
  ftd_meas_if.meas mi,
  // Fan tach pin
  input wire logic tach_raw
);
  logic sync1;
  logic sync2;
  logic filt;
  logic filt_q;
  logic [FILT_W-1:0] filt_cnt;
  logic [2:0] pre_cnt;
  logic [7:0] cnt;
  logic edge_cnt;
  ftd_tach_t state;
  wire rise = filt & ~filt_q;
  wire [2:0] div_last = (3'h1 << mi.div_sel) - 3'h1;
  wire gate_tick = mi.ref_tick && (pre_cnt == div_last);
  wire last_edge = edge_cnt == 1'((TACH_EDGES - 1) & 1);

  // Two-stage synchroniser on the pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= tach_raw;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt <= 1'b0;
      filt_cnt <= '0;
    end else if (sync2 == filt) begin
      filt_cnt <= '0;
    end else if (filt_cnt == FILT_W'(FILT_CYC - 1)) begin
      filt <= sync2;
      filt_cnt <= '0;
    end else begin
      filt_cnt <= filt_cnt + 1'b1;
    end
  end

  // Edge detect history
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q <= 1'b0;
    end else begin
      filt_q <= filt;
    end
  end

  // reference divided by the channel divisor
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= '0;
    end else if (state == T_IDLE || gate_tick) begin
      pre_cnt <= '0;
    end else if (mi.ref_tick) begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  // gate counting over two tach periods (one revolution)
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= T_IDLE;
      cnt <= '0;
      edge_cnt <= 1'b0;
      mi.done <= 1'b0;
      mi.count <= COUNT_MAX;
    end else begin
      mi.done <= 1'b0;
      case (state)
        T_IDLE: begin
          cnt <= '0;
          edge_cnt <= 1'b0;
          if (mi.start) begin
            state <= T_ARM;
          end
        end
        T_ARM: begin
          if (rise) begin
            cnt <= '0;
            state <= T_GATE;
          end else if (gate_tick && cnt == COUNT_MAX) begin
            mi.count <= COUNT_MAX;
            mi.done <= 1'b1;
            state <= T_IDLE;
          end else if (gate_tick) begin
            cnt <= cnt + 1'b1;
          end
        end
        T_GATE: begin
          if (rise && last_edge) begin
            mi.count <= cnt;
            mi.done <= 1'b1;
            state <= T_IDLE;
          end else if (rise) begin
            edge_cnt <= edge_cnt + 1'b1;
          end else if (gate_tick && cnt == COUNT_MAX) begin
            mi.count <= COUNT_MAX;
            mi.done <= 1'b1;
            state <= T_IDLE;
          end else if (gate_tick) begin
            cnt <= cnt + 1'b1;
          end
        end
        default: begin
          state <= T_IDLE;
        end
      endcase
    end
  end
endmodule
